// file: include/pew_pkg.sv
// constants and types shared by the page-write memory controller
package pew_pkg;
  localparam int CLK_MHZ = 100;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int PAGE_BYTES = 16;
  localparam int PAGE_LSB = 4;
  localparam int POLL_BIT = 7;
  // byte load spacing limit, microseconds
  localparam int LOAD_WINDOW_US = 20;
  // host keeps its spacing well inside the window
  localparam int LOAD_GAP_US = 10;
  localparam int LOAD_GAP_CYC = LOAD_GAP_US * CLK_MHZ;
  // strobe pulse widths, nanoseconds (well above the noise filter limit)
  localparam int NOISE_NS = 10;
  localparam int STROBE_NS = 100;
  localparam int STROBE_CYC = (STROBE_NS + 9) / 10;
  localparam int SETUP_CYC = 2;
  localparam int READ_CYC = 15;
  // programming time, microseconds, and poll timeout
  localparam int PROG_US = 5000;
  localparam int POLL_TIMEOUT_US = 20000;
  localparam int POLL_TIMEOUT_CYC = POLL_TIMEOUT_US * CLK_MHZ;
  typedef enum logic [2:0] {
    PEW_IDLE = 3'b000,
    PEW_SETUP = 3'b001,
    PEW_STROBE = 3'b010,
    PEW_HOLD = 3'b011,
    PEW_GAP = 3'b100,
    PEW_POLL = 3'b101,
    PEW_DONE = 3'b110
  } pew_state_e;
endpackage : pew_pkg

// file: include/pew_tmr_if.sv
// timer request and expiry between controller and its counter
`timescale 1ns/1ps
interface pew_tmr_if;
  logic load;
  logic [31:0] count;
  logic expired;
  modport ctl (output load, output count, input expired);
  modport tmr (input load, input count, output expired);
endinterface : pew_tmr_if

// file: hdl/pew_timer.sv
// down counter that flags when a loaded interval has run out
`timescale 1ns/1ps
module pew_timer
  import pew_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  pew_tmr_if.tmr t
);
  logic [31:0] remaining;

  // load takes priority so back-to-back intervals never merge
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      remaining <= 32'h0;
    else if (t.load)
      remaining <= t.count;
    else if (remaining != 32'h0)
      remaining <= remaining - 32'h1;
  end

  // expiry ignores load: load comes from the next state, which itself reads expiry
  assign t.expired = (remaining == 32'h0);
endmodule : pew_timer

// file: hdl/pew_host.sv
// host controller: byte, page write, completion poll and read of the memory
`timescale 1ns/1ps
module pew_host
  import pew_pkg::*;
#(
  parameter int POLL_TIMEOUT = POLL_TIMEOUT_CYC,
  parameter int LOAD_GAP = LOAD_GAP_CYC
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_data,
  input wire logic req_last,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_data,
  output logic rsp_timeout,
  output logic device_select_n,
  output logic output_drive_n,
  output logic write_strobe_n,
  output logic [ADDR_W-1:0] address_lines,
  output logic [DATA_W-1:0] data_lines_out,
  output logic data_lines_oe,
  input wire logic [DATA_W-1:0] data_lines_in
);
  pew_state_e state;
  pew_state_e next_state;
  pew_tmr_if tif ();
  logic is_write;
  logic in_page;
  logic [4:0] page_count;
  logic [ADDR_W-1:PAGE_LSB] page_tag;
  logic [DATA_W-1:0] last_data;
  logic [ADDR_W-1:0] last_addr;
  logic [31:0] poll_cnt;
  logic poll_phase;
  logic same_page;

  pew_timer u_tmr (
    .clk(clk),
    .rst_n(rst_n),
    .t(tif)
  );

  // a new write joins the open page only while room and tag match
  assign same_page = in_page && (req_addr[ADDR_W-1:PAGE_LSB] == page_tag)
                     && (page_count < 5'(PAGE_BYTES));
  // requests taken in idle, or in the load gap for a further page byte
  assign req_ready = (state == PEW_IDLE) || (state == PEW_GAP && req_valid && req_write && same_page);

  // state sequencing
  always_comb
  begin
    next_state = state;
    case (state)
      PEW_IDLE:
        if (req_valid)
          next_state = PEW_SETUP;
      PEW_SETUP:
        if (tif.expired)
          next_state = PEW_STROBE;
      PEW_STROBE:
        if (tif.expired)
          next_state = PEW_HOLD;
      PEW_HOLD:
        if (tif.expired)
          next_state = !is_write ? PEW_DONE : PEW_GAP;
      PEW_GAP:
        if (req_ready)
          next_state = PEW_SETUP;
        else if (tif.expired || req_valid || (page_count == 5'(PAGE_BYTES)))
          next_state = PEW_POLL;
      PEW_POLL:
        if (poll_phase && tif.expired && (data_lines_in[POLL_BIT] == last_data[POLL_BIT]))
          next_state = PEW_DONE;
        else if (poll_cnt >= 32'(POLL_TIMEOUT))
          next_state = PEW_DONE;
      PEW_DONE:
        next_state = PEW_IDLE;
      default:
        next_state = PEW_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= PEW_IDLE;
    else
      state <= next_state;
  end

  // timer loads on entry to each timed phase
  always_comb
  begin
    tif.load = 1'b0;
    tif.count = 32'h0;
    if (state != next_state || (state == PEW_POLL && tif.expired))
    begin
      case (next_state)
        PEW_SETUP: begin tif.load = 1'b1; tif.count = 32'(SETUP_CYC); end
        PEW_STROBE: begin tif.load = 1'b1; tif.count = is_write || (req_ready && req_write)
                      ? 32'(STROBE_CYC) : 32'(READ_CYC); end
        PEW_HOLD: begin tif.load = 1'b1; tif.count = 32'(SETUP_CYC); end
        PEW_GAP: begin tif.load = 1'b1; tif.count = 32'(LOAD_GAP); end // restarts per byte
        PEW_POLL: begin tif.load = 1'b1; tif.count = 32'(READ_CYC); end
        default: begin tif.load = 1'b0; tif.count = 32'h0; end
      endcase
    end
  end

  // capture request and track the open page
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      is_write <= 1'b0;
      in_page <= 1'b0;
      page_count <= 5'h0;
      page_tag <= '0;
      last_data <= 8'h0;
      last_addr <= 11'h0;
      address_lines <= 11'h0;
      data_lines_out <= 8'h0;
    end
    else if (req_valid && req_ready)
    begin
      is_write <= req_write;
      address_lines <= req_addr;
      data_lines_out <= req_data;
      if (req_write)
      begin
        last_data <= req_data;
        last_addr <= req_addr;
        page_tag <= req_addr[ADDR_W-1:PAGE_LSB];
        page_count <= (state == PEW_GAP) ? page_count + 5'h1 : 5'h1;
        in_page <= !req_last;
      end
    end
    else if (state == PEW_GAP && next_state == PEW_POLL)
    begin
      in_page <= 1'b0;
      address_lines <= last_addr; // poll the last byte written
    end
  end

  // poll phase toggles between settle intervals and read samples, output drive held low throughout
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      poll_phase <= 1'b0;
      poll_cnt <= 32'h0;
    end
    else if (state != PEW_POLL)
    begin
      poll_phase <= 1'b0;
      poll_cnt <= 32'h0;
    end
    else
    begin
      poll_cnt <= poll_cnt + 32'h1; // no programming step from host, only waiting
      if (tif.expired)
        poll_phase <= !poll_phase;
    end
  end

  // pins: write strobe only in strobe phase of a write, data driven from setup through hold of a write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      device_select_n <= 1'b1;
      output_drive_n <= 1'b1;
      write_strobe_n <= 1'b1;
      data_lines_oe <= 1'b0;
    end
    else
    begin
      device_select_n <= !(next_state == PEW_SETUP || next_state == PEW_STROBE
                           || next_state == PEW_HOLD || (next_state == PEW_POLL));
      write_strobe_n <= !(next_state == PEW_STROBE && (is_write || (req_ready && req_write)));
      output_drive_n <= !((next_state == PEW_STROBE && !(is_write || (req_ready && req_write)))
                          || (next_state == PEW_POLL));
      data_lines_oe <= (next_state == PEW_SETUP || next_state == PEW_STROBE || next_state == PEW_HOLD)
                       && (is_write || (req_ready && req_write));
    end
  end

  // response: read data sampled at end of read strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsp_valid <= 1'b0;
      rsp_data <= 8'h0;
      rsp_timeout <= 1'b0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      if (state == PEW_STROBE && tif.expired && !is_write)
        rsp_data <= data_lines_in;
      if (state == PEW_POLL && next_state == PEW_DONE)
      begin
        rsp_valid <= 1'b1; // inverted bit 7 keeps polling going
        rsp_timeout <= (poll_cnt >= 32'(POLL_TIMEOUT));
        rsp_data <= data_lines_in;
      end
      else if (state == PEW_HOLD && next_state == PEW_DONE)
      begin
        rsp_valid <= 1'b1;
        rsp_timeout <= 1'b0;
      end
    end
  end

  // pin and response guards on what the controller drives
  chk_strobe_no_read: assert property (@(posedge clk) disable iff (!rst_n)
    !(!write_strobe_n && !output_drive_n)) else $error("strobe and output drive low together");
  chk_oe_in_read: assert property (@(posedge clk) disable iff (!rst_n)
    !(data_lines_oe && !output_drive_n)) else $error("host drives data during read");
  chk_select_gates: assert property (@(posedge clk) disable iff (!rst_n)
    (!write_strobe_n || !output_drive_n) |-> !device_select_n) else $error("strobe without select");
  chk_strobe_width: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(write_strobe_n) |-> !write_strobe_n[*2]) else $error("write strobe too short");
  chk_data_held: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(write_strobe_n) |-> data_lines_oe && $stable(data_lines_out)) else $error("data not held at rise");
  chk_addr_stable: assert property (@(posedge clk) disable iff (!rst_n)
    !write_strobe_n |-> $stable(address_lines)) else $error("address moved during strobe");
  chk_page_bound: assert property (@(posedge clk) disable iff (!rst_n)
    page_count <= 5'(PAGE_BYTES)) else $error("page over sixteen bytes");
  // a finished poll must hand back the true bit 7 of the byte written
  chk_poll_done: assert property (@(posedge clk) disable iff (!rst_n)
    (rsp_valid && !rsp_timeout && $past(state == PEW_POLL))
    |-> rsp_data[POLL_BIT] == last_data[POLL_BIT]) else $error("poll ended on inverted bit");
endmodule : pew_host

// file: sim/pew_mem_model.sv
// behavioural model of the byte-alterable memory seen from the host pins
`timescale 1ns/1ps
module pew_mem_model
  import pew_pkg::*;
#(
  parameter int WINDOW_NS = LOAD_WINDOW_US * 1000,
  // shortened programming time so a run stays brief
  parameter int PROG_NS = 20000
)
(
  input wire logic device_select_n,
  input wire logic output_drive_n,
  input wire logic write_strobe_n,
  input wire logic [ADDR_W-1:0] address_lines,
  input wire logic [DATA_W-1:0] data_in,
  output logic drive_en,
  output logic [DATA_W-1:0] drive_data
);
  logic [DATA_W-1:0] mem [0:2047];
  logic [DATA_W-1:0] page_d [0:PAGE_BYTES-1];
  logic [PAGE_BYTES-1:0] page_v;
  logic [ADDR_W-1:0] a_lat;
  logic [ADDR_W-1:0] last_a;
  logic [DATA_W-1:0] last_d;
  logic busy;
  int gen;
  realtime t_start;
  wire wr = !device_select_n && !write_strobe_n && output_drive_n;
  // known contents so read-back of untouched bytes is predictable
  initial
  begin
    busy = 1'b0;
    page_v = '0;
    gen = 0;
    for (int i = 0; i < 2048; i++)
      mem[i] = i[7:0] ^ 8'h3c;
  end
  // write forms on the later falling edge; each one while not busy restarts the load window
  always @(posedge wr)
  begin
    t_start = $realtime;
    a_lat = address_lines;
    if (!busy)
    begin
      gen++;
      fork
        close_page(gen);
      join_none
    end
  end
  // data taken on the first rising edge; glitches load nothing
  always @(negedge wr)
  begin
    if (!busy && $realtime - t_start >= NOISE_NS)
    begin
      page_d[a_lat[3:0]] = data_in;
      page_v[a_lat[3:0]] = 1'b1;
      last_a = a_lat;
      last_d = data_in;
    end
  end
  // window expiry closes the page and programs it unattended
  task automatic close_page(input int g);
    #(WINDOW_NS);
    if (g == gen && page_v != '0)
    begin
      busy = 1'b1;
      #(PROG_NS);
      for (int i = 0; i < PAGE_BYTES; i++)
        if (page_v[i])
          mem[{last_a[10:4], i[3:0]}] = page_d[i];
      page_v = '0;
      busy = 1'b0;
    end
  endtask : close_page
  // drive only while selected and output drive low, strobe high
  assign drive_en = !device_select_n && !output_drive_n && write_strobe_n;
  // an open page counts as a write in progress, so an early poll never sees stale bit 7
  assign drive_data = ((busy || page_v != '0) && address_lines == last_a)
                      ? {~last_d[7], last_d[6:0]} : mem[address_lines];
endmodule : pew_mem_model

// file: sim/test_parallel_eeprom_page_write_poll.sv
// self-checking bench: host controller against the memory model
`timescale 1ns/1ps
module test_parallel_eeprom_page_write_poll;
  import pew_pkg::*;
  logic clk, rst_n, req_valid, req_write, req_last;
  logic [ADDR_W-1:0] req_addr;
  logic [DATA_W-1:0] req_data, bus_last;
  wire req_ready, rsp_valid, rsp_timeout, sel_n, od_n, ws_n, oe, dev_en;
  wire [ADDR_W-1:0] addr;
  wire [DATA_W-1:0] dout, rsp_data, dev_d;
  // released bus shows the inverse of its last level, never a kind value
  wire [DATA_W-1:0] bus = oe ? dout : (dev_en ? dev_d : ~bus_last);
  int n_errors, n_checks;
  pew_host #(.POLL_TIMEOUT(5000), .LOAD_GAP(20)) dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr), .req_data(req_data), .req_last(req_last),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_timeout(rsp_timeout), .device_select_n(sel_n),
    .output_drive_n(od_n), .write_strobe_n(ws_n), .address_lines(addr), .data_lines_out(dout),
    .data_lines_oe(oe), .data_lines_in(bus));
  pew_mem_model mem (.device_select_n(sel_n), .output_drive_n(od_n), .write_strobe_n(ws_n),
    .address_lines(addr), .data_in(bus), .drive_en(dev_en), .drive_data(dev_d));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
    bus_last <= bus;
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    if (n_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  // both parties never drive the data bus at once; strobe only while selected
  always @(negedge clk)
    if (rst_n && (oe && dev_en || !ws_n && (sel_n || !od_n)))
      check({1'b0, 8'h01}, 9'h000);
  // hold request until accepted
  task automatic req(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic l);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_data <= d;
    req_last <= l;
    for (int i = 0; i <= 2000; i++)
    begin
      @(negedge clk);
      if (req_ready === 1'b1)
        break;
      if (i == 2000)
        check(9'h1ff, 9'h000);
      if (i == 2000)
        complete_run();
    end
    @(posedge clk);
    req_valid <= 1'b0;
    // one idle edge so a following call never re-raises valid in this time step
    @(posedge clk);
  endtask : req
  // bounded wait for the one-cycle response, then compare it
  task automatic wait_rsp(input logic [DATA_W-1:0] exp);
    for (int i = 0; i <= 20000; i++)
    begin
      @(negedge clk);
      if (rsp_valid === 1'b1)
        break;
      if (i == 20000)
        check(9'h1fe, 9'h000);
      if (i == 20000)
        complete_run();
    end
    check({rsp_timeout, rsp_data}, {1'b0, exp});
    @(posedge clk);
  endtask : wait_rsp
  function automatic logic [7:0] pdat(input int i);
    return {i[3:0], ~i[3:0]} ^ 8'h80;
  endfunction : pdat
  // single bytes at both address extremes, polarity of bit 7 both ways
  task automatic sc_byte();
    req(1'b1, 11'h7ff, 8'h5a, 1'b1);
    wait_rsp(8'h5a);
    req(1'b1, 11'h000, 8'ha5, 1'b1);
    wait_rsp(8'ha5);
    req(1'b0, 11'h7ff, 8'h00, 1'b0);
    wait_rsp(8'h5a);
    req(1'b0, 11'h000, 8'h00, 1'b0);
    wait_rsp(8'ha5);
  endtask : sc_byte
  // full sixteen-byte page, read back plus untouched neighbour
  task automatic sc_page();
    for (int i = 0; i < PAGE_BYTES; i++)
      req(1'b1, {7'h2a, i[3:0]}, pdat(i), i == PAGE_BYTES - 1);
    wait_rsp(pdat(PAGE_BYTES - 1));
    for (int i = 0; i < PAGE_BYTES; i++)
    begin
      req(1'b0, {7'h2a, i[3:0]}, 8'h00, 1'b0);
      wait_rsp(pdat(i));
    end
    req(1'b0, 11'h2b0, 8'h00, 1'b0);
    wait_rsp(8'hb0 ^ 8'h3c);
  endtask : sc_page
  // shortest page: two loads, closed by the gap running out rather than a last flag
  task automatic sc_pair();
    req(1'b1, 11'h135, 8'h11, 1'b0);
    req(1'b1, 11'h13a, 8'hee, 1'b0);
    wait_rsp(8'hee);
    req(1'b0, 11'h135, 8'h00, 1'b0);
    wait_rsp(8'h11);
    req(1'b0, 11'h13a, 8'h00, 1'b0);
    wait_rsp(8'hee);
  endtask : sc_pair
  initial
  begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_last = 1'b0;
    req_addr = '0;
    req_data = '0;
    n_errors = 0;
    n_checks = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    sc_byte();
    sc_page();
    sc_pair();
    complete_run();
  end
endmodule : test_parallel_eeprom_page_write_poll
